// [core/phy_shadow_map.svh]
// offsets, field positions, reset values and timing figures of the shadow bank
`ifndef PHY_SHADOW_MAP_SVH
`define PHY_SHADOW_MAP_SVH

// ****************************************************************
// register address and field layout
// ****************************************************************
`define SHADOW_REG_ADDR   12'h038
`define WE_BIT            15
`define SEL_HI            14
`define SEL_LO            10
`define APD_EN_BIT        5
`define APD_SLEEP_BIT     4
`define APD_WAKE_HI       3
`define APD_WAKE_LO       0

// ****************************************************************
// reset values
// ****************************************************************
`define APD_RST           6'h01
`define LED_RST           8'h63

// ****************************************************************
// lamp selector codes
// ****************************************************************
`define LAMP_CODE_INTERRUPT_INDICATOR    4'h6
`define LAMP_CODE_XMIT    4'h2
`define LAMP_CODE_OFF     4'he
`define LAMP_CODE_ON      4'hf

// ****************************************************************
// bus answers
// ****************************************************************
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ****************************************************************
// timing
// ****************************************************************
`define CLK_MHZ           200
`define WAKE_UNIT_MS      84
`define SLEEP_SHORT_MS    2700
`define SLEEP_LONG_MS     5400

`endif

// [core/phy_shadow_pkg.sv]
// types shared by the shadow register bank and its lamp selectors
`default_nettype none
package phy_shadow_pkg;

	typedef enum logic [4:0] {
		SHADOW_APD = 5'b01010,
		SHADOW_LED = 5'b01110
	} shadow_sel_e;

	typedef logic [15:0] shadow_word_t;
	typedef logic [3:0]  lamp_code_t;

endpackage

`default_nettype wire

// [core/lamp_if.sv]
// selector code and candidate levels passed to one lamp selector
`timescale 1ns/1ps
`default_nettype none

interface lamp_if;
	logic [3:0]  code;
	logic [15:0] level_table;
	logic        pin_n;

	modport mux (input code, input level_table, output pin_n);
	modport ctl (output code, output level_table, input pin_n);
endinterface

`default_nettype wire

// [core/lamp_select.sv]
// one lamp output: picks the level chosen by its selector code
`timescale 1ns/1ps
`default_nettype none
`include "phy_shadow_map.svh"

module lamp_select
	import phy_shadow_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_reset,
	lamp_if.mux       port
);

	logic pin_r;

	// ****************************************************************
	// registered pin so the lamp never glitches while codes change
	// ****************************************************************
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pin_r <= 1'b1;
		end else begin
			pin_r <= port.level_table[port.code];
		end
	end

	assign port.pin_n = pin_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence force_off_s;
		(port.code == `LAMP_CODE_OFF) [*2];
	endsequence

	sequence force_on_s;
		(port.code == `LAMP_CODE_ON) [*2];
	endsequence

	AST_FORCE_OFF_HIGH: assert property (force_off_s |-> port.pin_n)
		else $error("forced-off lamp not high");

	AST_FORCE_ON_LOW: assert property (force_on_s |-> !port.pin_n)
		else $error("forced-on lamp not low");

endmodule

`default_nettype wire

// [core/phy_shadow_regs.sv]
// shadowed power-down and lamp selection registers behind one AXI4-Lite word
`timescale 1ns/1ps
`default_nettype none
`include "phy_shadow_map.svh"

// Overview of operation
// - bit 15 set writes bits 9:0, else selects
// - selector 01010 reaches power-down register
// - selector 01110 reaches lamp selection register
// - bit 5 enables auto power-down, resets off
// - bit 4 picks 5.4 s or 2.7 s sleep
// - bits 3:0 wake-up interval in 84 ms, reset 1
// - reserved bits written zero, read as zero
// - lamp codes 0000-1011 select status sources
// - 1101 carrier sense, 1110 off, 1111 on
// - select with bit 15 clear, then read
// - energy detect replaces interrupt when routed
module phy_shadow_regs
	import phy_shadow_pkg::*;
#(
	parameter int unsigned WAKE_UNIT_CYCLES   = `WAKE_UNIT_MS * 1000 * `CLK_MHZ,
	parameter int unsigned SLEEP_SHORT_CYCLES = `SLEEP_SHORT_MS * 1000 * `CLK_MHZ,
	parameter int unsigned SLEEP_LONG_CYCLES  = `SLEEP_LONG_MS * 1000 * `CLK_MHZ
)
(
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RESET,
	input  wire logic [11:0] I_AWADDR,
	input  wire logic        I_AWVALID,
	output var  logic        O_AWREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output var  logic        O_WREADY,
	output var  logic [1:0]  O_BRESP,
	output var  logic        O_BVALID,
	input  wire logic        I_BREADY,
	input  wire logic [11:0] I_ARADDR,
	input  wire logic        I_ARVALID,
	output var  logic        O_ARREADY,
	output var  logic [31:0] O_RDATA,
	output var  logic [1:0]  O_RRESP,
	output var  logic        O_RVALID,
	input  wire logic        I_RREADY,
	input  wire logic [1:0]  I_LINK_RATE_INDICATOR,
	input  wire logic        I_TRANSMIT_INDICATOR,
	input  wire logic        I_ACTIVITY,
	input  wire logic        I_FULL_DUPLEX_INDICATOR,
	input  wire logic        I_SLAVE,
	input  wire logic        I_INTERRUPT_INDICATOR,
	input  wire logic        I_LINK_INDICATOR_A,
	input  wire logic        I_RECEIVE_INDICATOR,
	input  wire logic        I_SPEED_DOWNGRADE_INDICATOR,
	input  wire logic [1:0]  I_MULTI_COLOUR_INDICATOR,
	input  wire logic        I_CABLE_FAULT,
	input  wire logic        I_CARRIER_SENSE,
	input  wire logic        I_ENERGY_DETECT,
	input  wire logic        I_ENERGY_ROUTE_EN,
	output var  logic        O_APD_ENABLE,
	output var  logic [3:0]  O_WAKE_UNITS,
	output var  logic [31:0] O_SLEEP_CYCLES,
	output var  logic        O_WAKE_TICK,
	output var  logic        O_LAMP_THIRD_N,
	output var  logic        O_LAMP_FOURTH_N
);

	// ****************************************************************
	// bus slave state
	// ****************************************************************
	logic        aw_hold_r;
	logic        w_hold_r;
	logic [11:0] awaddr_r;
	logic [15:0] wdata_r;
	logic [1:0]  wstrb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;

	logic [4:0]   sel_r;
	logic [5:0]   apd_r;
	logic [7:0]   led_r;
	shadow_word_t cur_word;
	shadow_word_t merged;
	logic         do_write;
	logic         hit_w;
	logic         hit_r;
	logic         rd_take;

	assign O_AWREADY = !aw_hold_r;
	assign O_WREADY  = !w_hold_r;
	assign O_BVALID  = bvalid_r;
	assign O_BRESP   = bresp_r;
	assign O_ARREADY = !rvalid_r;
	assign O_RVALID  = rvalid_r;
	assign O_RDATA   = rdata_r;
	assign O_RRESP   = rresp_r;

	assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
	assign hit_w    = awaddr_r == `SHADOW_REG_ADDR;
	assign hit_r    = {I_ARADDR[11:2], 2'h0} == `SHADOW_REG_ADDR;
	assign rd_take  = I_ARVALID && !rvalid_r;

	// reserved bits are not stored, so they always read back as zero
	always_comb begin
		cur_word = '0;
		cur_word[`SEL_HI:`SEL_LO] = sel_r;
		if (sel_r == SHADOW_APD) begin
			cur_word[5:0] = apd_r;
		end else if (sel_r == SHADOW_LED) begin
			cur_word[7:0] = led_r;
		end
	end

	// lanes without a strobe keep what the word shows now
	assign merged = {wstrb_r[1] ? wdata_r[15:8] : cur_word[15:8],
	                 wstrb_r[0] ? wdata_r[7:0]  : cur_word[7:0]};

	// ****************************************************************
	// write channels, taken in either order
	// ****************************************************************
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			aw_hold_r <= 1'b0;
			awaddr_r  <= 12'h000;
		end else if (I_AWVALID && !aw_hold_r) begin
			aw_hold_r <= 1'b1;
			awaddr_r  <= {I_AWADDR[11:2], 2'h0};
		end else if (do_write) begin
			aw_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			w_hold_r <= 1'b0;
			wdata_r  <= 16'h0000;
			wstrb_r  <= 2'h0;
		end else if (I_WVALID && !w_hold_r) begin
			w_hold_r <= 1'b1;
			wdata_r  <= I_WDATA[15:0];
			wstrb_r  <= I_WSTRB[1:0];
		end else if (do_write) begin
			w_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			bvalid_r <= 1'b0;
			bresp_r  <= `RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= hit_w ? `RESP_OKAY : `RESP_SLVERR;
		end else if (I_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end

	// ****************************************************************
	// shadow selector and the two shadow registers
	// ****************************************************************
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			sel_r <= 5'h00;
		end else if (do_write && hit_w) begin
			sel_r <= merged[`SEL_HI:`SEL_LO];
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			apd_r <= `APD_RST;
		end else if (do_write && hit_w && merged[`WE_BIT] &&
		             merged[`SEL_HI:`SEL_LO] == SHADOW_APD) begin
			apd_r <= merged[5:0];
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			led_r <= `LED_RST;
		end else if (do_write && hit_w && merged[`WE_BIT] &&
		             merged[`SEL_HI:`SEL_LO] == SHADOW_LED) begin
			led_r <= merged[7:0];
		end
	end

	// ****************************************************************
	// read channel
	// ****************************************************************
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= `RESP_OKAY;
		end else if (rd_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= hit_r ? {16'h0000, cur_word} : 32'h0000_0000;
			rresp_r  <= hit_r ? `RESP_OKAY : `RESP_SLVERR;
		end else if (I_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	// ****************************************************************
	// power-down controls and wake-up unit divider
	// ****************************************************************
	logic [31:0] wake_cnt_r;
	logic [31:0] sleep_cycles_r;
	logic        wake_tick_r;

	assign O_APD_ENABLE   = apd_r[`APD_EN_BIT];
	assign O_WAKE_UNITS   = apd_r[`APD_WAKE_HI:`APD_WAKE_LO];
	assign O_SLEEP_CYCLES = sleep_cycles_r;
	assign O_WAKE_TICK    = wake_tick_r;

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			sleep_cycles_r <= SLEEP_SHORT_CYCLES;
		end else begin
			sleep_cycles_r <= apd_r[`APD_SLEEP_BIT] ? SLEEP_LONG_CYCLES
			                                        : SLEEP_SHORT_CYCLES;
		end
	end

	// the divider idles while the feature is off to save toggling
	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET || !apd_r[`APD_EN_BIT]) begin
			wake_cnt_r  <= 32'h0000_0000;
			wake_tick_r <= 1'b0;
		end else if (wake_cnt_r == WAKE_UNIT_CYCLES - 1) begin
			wake_cnt_r  <= 32'h0000_0000;
			wake_tick_r <= 1'b1;
		end else begin
			wake_cnt_r  <= wake_cnt_r + 32'h0000_0001;
			wake_tick_r <= 1'b0;
		end
	end

	// ****************************************************************
	// status source synchronisers
	// ****************************************************************
	logic [14:0] src_raw;
	logic [14:0] src_meta_r;
	logic [14:0] src_s_r;
	logic        interrupt_indicator_eff;

	assign src_raw = {I_ENERGY_DETECT, I_CARRIER_SENSE, I_CABLE_FAULT,
	                  I_MULTI_COLOUR_INDICATOR, I_SPEED_DOWNGRADE_INDICATOR,
	                  I_RECEIVE_INDICATOR, I_LINK_INDICATOR_A,
	                  I_INTERRUPT_INDICATOR, I_SLAVE, I_FULL_DUPLEX_INDICATOR,
	                  I_ACTIVITY, I_TRANSMIT_INDICATOR, I_LINK_RATE_INDICATOR};

	always_ff @(posedge I_REF_CLK) begin
		if (I_RESET) begin
			src_meta_r <= 15'h0000;
			src_s_r    <= 15'h0000;
		end else begin
			src_meta_r <= src_raw;
			src_s_r    <= src_meta_r;
		end
	end

	// energy detect borrows the interrupt code rather than a code of its own
	assign interrupt_indicator_eff = I_ENERGY_ROUTE_EN ? src_s_r[14] : src_s_r[6];

	// ****************************************************************
	// lamp selectors: index 0 is the third lamp, 1 the fourth
	// ****************************************************************
	lamp_if lamp [2] ();

	for (genvar g = 0; g < 2; g++) begin : g_lamp
		assign lamp[g].code = led_r[g*4 +: 4];
		// pins are active low: a true status pulls the lamp on
		assign lamp[g].level_table = {1'b0, 1'b1, ~src_s_r[13], 1'b1,
		                              ~src_s_r[12], ~src_s_r[10 + g],
		                              ~src_s_r[9], ~src_s_r[8], ~src_s_r[7],
		                              ~interrupt_indicator_eff, ~src_s_r[5:2],
		                              ~src_s_r[1], ~src_s_r[0]};
		lamp_select u_lamp (
			.i_clk   (I_REF_CLK),
			.i_reset (I_RESET),
			.port    (lamp[g].mux)
		);
	end

	assign O_LAMP_THIRD_N  = lamp[0].pin_n;
	assign O_LAMP_FOURTH_N = lamp[1].pin_n;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_RESET);

	sequence apd_write_s;
		do_write && hit_w && merged[`WE_BIT] &&
		merged[`SEL_HI:`SEL_LO] == SHADOW_APD;
	endsequence

	sequence select_only_s;
		do_write && hit_w && !merged[`WE_BIT];
	endsequence

	AST_WE_WRITES_APD: assert property (
		apd_write_s |=> apd_r == $past(merged[5:0]))
		else $error("enabled write did not reach power-down bits");

	AST_WE_CLEAR_KEEPS: assert property (
		select_only_s |=> $stable(apd_r) && $stable(led_r))
		else $error("select-only write changed a shadow register");

	AST_APD_CODE_READ: assert property (
		rd_take && hit_r && sel_r == SHADOW_APD |=>
		O_RDATA[`SEL_HI:`SEL_LO] == SHADOW_APD && O_RVALID)
		else $error("power-down selector not read back");

	AST_LED_CODE_READ: assert property (
		rd_take && hit_r && sel_r == SHADOW_LED |=>
		O_RDATA[`SEL_HI:`SEL_LO] == SHADOW_LED && O_RVALID)
		else $error("lamp selector code not read back");

	AST_APD_RESET: assert property (
		$past(I_RESET) |-> !O_APD_ENABLE)
		else $error("power-down enabled after reset");

	AST_SLEEP_SELECT: assert property (
		!$past(I_RESET) |-> O_SLEEP_CYCLES == ($past(apd_r[`APD_SLEEP_BIT]) ?
		SLEEP_LONG_CYCLES : SLEEP_SHORT_CYCLES))
		else $error("sleep duration does not follow its select bit");

	AST_WAKE_RESET: assert property (
		$past(I_RESET) |-> O_WAKE_UNITS == 4'h1 && !O_WAKE_TICK)
		else $error("wake-up interval not one unit after reset");

	AST_RSVD_READ_ZERO: assert property (
		rd_take && hit_r |=> O_RDATA[31:16] == 16'h0000 && !O_RDATA[`WE_BIT]
		&& (O_RDATA[`SEL_HI:`SEL_LO] != SHADOW_APD || O_RDATA[9:6] == 4'h0))
		else $error("reserved bits read nonzero");

	AST_SOURCE_SELECT: assert property (
		led_r[7:4] == `LAMP_CODE_XMIT |=>
		O_LAMP_FOURTH_N == !$past(src_s_r[2]))
		else $error("fourth lamp does not follow transmit status");

	AST_LAMP_RESET: assert property (
		$past(I_RESET) |-> led_r == `LED_RST)
		else $error("lamp selector fields wrong after reset");

	AST_READ_AFTER_SELECT: assert property (
		rd_take && hit_r && sel_r == SHADOW_LED |=>
		O_RDATA[7:0] == $past(led_r) && O_RRESP == `RESP_OKAY)
		else $error("read after select returned wrong contents");

	AST_ENERGY_ROUTE: assert property (
		led_r[3:0] == `LAMP_CODE_INTERRUPT_INDICATOR && I_ENERGY_ROUTE_EN |=>
		O_LAMP_THIRD_N == !$past(src_s_r[14]))
		else $error("energy detect not shown on interrupt lamp");

endmodule

`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the shadow power-down and lamp selector bank
`timescale 1ns/1ps
`default_nettype none

module testbench
	import phy_shadow_pkg::*;
();
	// ****************************************************************
	// signals
	// ****************************************************************
	localparam int WU = 8;
	localparam int SS = 100;
	localparam int SL = 200;

	logic        clk;
	logic        rst;
	logic [11:0] awaddr;
	logic [11:0] araddr;
	logic [31:0] wdata;
	logic        awvalid;
	logic        wvalid;
	logic        bready;
	logic        arvalid;
	logic        rready;
	logic        route;
	logic [3:0]  strb;
	logic [14:0] st;
	logic        awready;
	logic        wready;
	logic        bvalid;
	logic        arready;
	logic        rvalid;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic [31:0] rdata;
	logic        apd_en;
	logic [3:0]  wake;
	logic [31:0] sleep;
	logic        tick;
	logic        l3;
	logic        l4;
	logic [31:0] v;
	logic [1:0]  r2;
	int          n_fail;
	int          num_checks;
	int          seed;
	int          apd;
	int          led;
	int          sel;
	int          c;
	int          k;
	int          cnt;
	int          t[$];

	phy_shadow_regs #(.WAKE_UNIT_CYCLES(WU), .SLEEP_SHORT_CYCLES(SS),
		.SLEEP_LONG_CYCLES(SL)) DUT (
		.I_REF_CLK(clk), .I_RESET(rst),
		.I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
		.I_WDATA(wdata), .I_WSTRB(strb), .I_WVALID(wvalid),
		.O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
		.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
		.O_RVALID(rvalid), .I_RREADY(rready),
		.I_LINK_RATE_INDICATOR(st[1:0]), .I_TRANSMIT_INDICATOR(st[2]),
		.I_ACTIVITY(st[3]), .I_FULL_DUPLEX_INDICATOR(st[4]),
		.I_SLAVE(st[5]), .I_INTERRUPT_INDICATOR(st[6]),
		.I_LINK_INDICATOR_A(st[7]), .I_RECEIVE_INDICATOR(st[8]),
		.I_SPEED_DOWNGRADE_INDICATOR(st[9]),
		.I_MULTI_COLOUR_INDICATOR({st[12], st[10]}),
		.I_CABLE_FAULT(st[11]), .I_CARRIER_SENSE(st[13]),
		.I_ENERGY_DETECT(st[14]), .I_ENERGY_ROUTE_EN(route),
		.O_APD_ENABLE(apd_en), .O_WAKE_UNITS(wake),
		.O_SLEEP_CYCLES(sleep), .O_WAKE_TICK(tick),
		.O_LAMP_THIRD_N(l3), .O_LAMP_FOURTH_N(l4)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ****************************************************************
	// checking and bus tasks
	// ****************************************************************
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// handshakes are judged mid-cycle and released right after the edge
	task axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ah, wh, bh;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bh = 1'b0;
		while (!bh) begin
			@(negedge clk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			r = bresp;
			@(posedge clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		@(posedge clk);
	endtask

	task axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ah, rh;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rh = 1'b0;
		while (!rh) begin
			@(negedge clk);
			ah = arvalid && arready;
			rh = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk);
			if (ah) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge clk);
	endtask

	// write the shared word and follow it in the model
	task rw(input logic [15:0] d);
		logic [1:0] r;
		axw(12'h038, {16'h0, d}, r);
		chk("bresp", 2'h0, r);
		sel = d[14:10];
		if (d[15] && sel == SHADOW_APD) apd = d[5:0];
		if (d[15] && sel == SHADOW_LED) led = d[7:0];
	endtask

	task rcmp;
		logic [31:0] d;
		logic [1:0]  r;
		int          e;
		axr(12'h038, d, r);
		e = sel << 10;
		if (sel == SHADOW_APD) e = e | apd;
		if (sel == SHADOW_LED) e = e | led;
		chk("rresp", 2'h0, r);
		chk("rdata", e, d);
		chk("apd_en", apd >> 5 & 1, apd_en);
		chk("wake", apd & 15, wake);
		chk("sleep", (apd >> 4 & 1) ? SL : SS, sleep);
	endtask

	// lamp pin is the inverse of the chosen source; reserved code reads off
	function logic lamp(input int cd, input logic mc);
		logic s;
		case (cd)
			10: s = mc;
			12, 14: return 1'b1;
			15: return 1'b0;
			6: s = route ? st[14] : st[6];
			default: s = st[cd];
		endcase
		return !s;
	endfunction

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		$display("[ERR] watchdog expected done seen hang");
		finish_test();
	end

	initial begin
		seed = 32'h06b6eb6a;
		n_fail = 0;
		num_checks = 0;
		apd = 1;
		led = 'h63;
		sel = 0;
		{rst, awvalid, wvalid, bready, arvalid, rready, route} = 7'h40;
		{awaddr, araddr, wdata, st} = '0;
		strb = 4'hf;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rcmp();
		rw(16'h2800);
		rcmp();
		rw(16'h3800);
		rcmp();
		$display("reset test done");
		repeat (6) begin
			v = $random(seed);
			rw({1'b1, 5'b01010, v[9:0]});
			rcmp();
			rw({1'b0, 5'b01010, ~v[9:0]});
			rcmp();
			rw({1'b1, 5'b00100, v[9:0]});
			rcmp();
			rw({1'b1, 5'b01110, v[25:16]});
			rcmp();
		end
		$display("field test done");
		axw(12'h03c, 32'hffff, r2);
		chk("bresp_bad", 2'h2, r2);
		axr(12'h03c, v, r2);
		chk("rresp_bad", 2'h2, r2);
		chk("rdata_bad", 32'h0, v);
		rcmp();
		$display("unmapped test done");
		// upper lane only: the lower byte keeps what the word shows now
		rw(16'h3800);
		strb <= 4'h2;
		axw(12'h038, 32'h0000_b8a5, r2);
		strb <= 4'hf;
		chk("bresp_lane", 2'h0, r2);
		rcmp();
		$display("strobe test done");
		for (c = 0; c < 16; c++) begin
			rw({1'b1, 5'b01110, 2'b00, c[3:0], c[3:0]});
			for (k = 0; k < 3; k++) begin
				v = $random(seed);
				{route, st} <= {k[0], v[14:0]};
				repeat (5) @(posedge clk);
				@(negedge clk);
				chk("lamp3", lamp(c, st[10]), l3);
				chk("lamp4", lamp(c, st[12]), l4);
				@(posedge clk);
			end
		end
		$display("lamp test done");
		rw(16'ha833);
		rcmp();
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			if (tick) t.push_back(k);
		end
		chk("tick_gap", WU, t[1] - t[0]);
		chk("tick_gap2", WU, t[2] - t[1]);
		@(posedge clk);
		rw(16'ha801);
		cnt = 0;
		repeat (20) begin
			@(negedge clk);
			if (tick) cnt++;
		end
		chk("tick_off", 0, cnt);
		$display("wake test done");
		finish_test();
	end
endmodule

`default_nettype wire
